// ### design/ecbc_top.v
// EEPROM command and busy control: register port, serial EEPROM engine and post-reset address load.
// Assumes a serial EEPROM with select, clock, data-in and data-out pins, and one 250 MHz system clock.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "ecbc_map.vh"
// What this block does
// RULE1 - Writing one to busy bit starts the selected command at the selected address.
// RULE2 - Busy flag stays one throughout a command and clears itself only at completion.
// RULE3 - A read places the EEPROM word in the data register before busy clears.
// RULE4 - Host leaves command and data registers alone while busy is set.
// RULE5 - With no EEPROM attached a write holds busy until timeout, then clears.
// RULE6 - Busy flag is high immediately after power-up or any reset.
// RULE7 - After reset the station address is loaded, then busy clears.
// RULE8 - Writing zero to the busy bit has no effect on a running command.
module ecbc_top #(
  parameter integer TOUT_CYCLES = (`ECBC_TOUT_US * 1000) / `ECBC_CLK_PERIOD_NS
) (
  input wire REF_CLK_I,
  input wire RST_N_I,
  input wire [7:0] ADDR_I,
  input wire [31:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [31:0] RDATA_O,
  output reg IRQ_O,
  output reg EE_CS_O,
  output reg EE_SK_O,
  output reg EE_DI_O,
  input wire EE_DO_I,
  output reg [47:0] MAC_ADDR_O
);
  localparam integer BIT_DIV = `ECBC_BIT_PERIOD_NS / `ECBC_CLK_PERIOD_NS;
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SHIFT = 3'h1;
  localparam [2:0] ST_WAIT = 3'h2;
  localparam [2:0] ST_GAP = 3'h3;
  localparam [2:0] ST_DONE = 3'h4;

  reg busy_q;
  reg loading_q;
  reg [2:0] load_idx_q;
  reg [2:0] state_q;
  reg [2:0] cmd_q;
  reg [7:0] addr_q;
  reg [7:0] data_q;
  reg tout_q;
  reg loaded_q;
  reg [2:0] stat_q;
  reg [2:0] en_q;
  reg [19:0] shreg_q;
  reg [4:0] bits_q;
  reg sk_phase_q;
  reg [31:0] tcnt_q;
  reg [31:0] rd_mux;
  wire tick;
  wire do_sync;
  wire start_host;
  wire wr_cmd;
  wire wr_data;
  wire wr_clr;
  wire wr_en;
  reg ev_done;
  reg ev_tout;
  reg ev_load;

  function [19:0] ecbc_frame;
    input [2:0] op;
    input [7:0] a;
    input [7:0] d;
    begin
      ecbc_frame = {1'b1, op, a, d};
    end
  endfunction

  // One decode serves every write strobe; the read mux applies the address map separately.
  function ecbc_hit;
    input strobe;
    input [7:0] addr;
    input [7:0] off;
    begin
      ecbc_hit = strobe && (addr == off);
    end
  endfunction

  assign wr_cmd = ecbc_hit(WR_I, ADDR_I, `ECBC_CMD_OFF);
  assign wr_data = ecbc_hit(WR_I, ADDR_I, `ECBC_DATA_OFF);
  assign wr_clr = ecbc_hit(WR_I, ADDR_I, `ECBC_IRQ_CLR_OFF);
  assign wr_en = ecbc_hit(WR_I, ADDR_I, `ECBC_IRQ_EN_OFF);

  ecbc_divider #(
    .DIV(BIT_DIV)
  ) u_div (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .run_i(busy_q),
    .tick_o(tick)
  );

  ecbc_sync u_sync (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .pin_i(EE_DO_I),
    .level_o(do_sync)
  );

  // Host start only counts while idle; a zero written to the busy bit never touches the engine.
  assign start_host = wr_cmd && WDATA_I[`ECBC_BUSY_BIT] && !busy_q; // [RULE1] [RULE8]

  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      busy_q <= 1'b1; // [RULE6]
      loading_q <= 1'b1;
      load_idx_q <= 3'h0;
      state_q <= ST_IDLE;
      cmd_q <= `ECBC_CMD_READ;
      addr_q <= 8'h00;
      data_q <= 8'h00;
      tout_q <= 1'b0;
      loaded_q <= 1'b0;
      shreg_q <= 20'h00000;
      bits_q <= 5'h00;
      sk_phase_q <= 1'b0;
      tcnt_q <= 32'h00000000;
      EE_CS_O <= 1'b0;
      EE_SK_O <= 1'b0;
      EE_DI_O <= 1'b0;
      MAC_ADDR_O <= 48'h000000000000;
      ev_done <= 1'b0;
      ev_tout <= 1'b0;
      ev_load <= 1'b0;
    end else begin
      ev_done <= 1'b0;
      ev_tout <= 1'b0;
      ev_load <= 1'b0;
      // Command and data registers are only writable while idle, so a careless host cannot corrupt a command.
      if (wr_cmd && !busy_q) begin // [RULE8]
        cmd_q <= WDATA_I[`ECBC_CMD_MSB:`ECBC_CMD_LSB];
        addr_q <= WDATA_I[`ECBC_ADDR_MSB:`ECBC_ADDR_LSB];
        if (WDATA_I[`ECBC_TOUT_BIT]) begin
          tout_q <= 1'b0;
        end
      end
      if (wr_data && !busy_q) begin
        data_q <= WDATA_I[7:0];
      end
      if (start_host) begin
        busy_q <= 1'b1; // [RULE1]
      end
      case (state_q)
        ST_IDLE: begin
          if (loading_q) begin
            shreg_q <= ecbc_frame(`ECBC_CMD_READ, {5'h00, load_idx_q}, 8'h00); // [RULE7]
            bits_q <= 5'h14;
            tcnt_q <= 32'h00000000;
            state_q <= ST_SHIFT;
          end else if (start_host) begin
            shreg_q <= ecbc_frame(WDATA_I[`ECBC_CMD_MSB:`ECBC_CMD_LSB], WDATA_I[`ECBC_ADDR_MSB:`ECBC_ADDR_LSB],
              data_q);
            cmd_q <= WDATA_I[`ECBC_CMD_MSB:`ECBC_CMD_LSB];
            bits_q <= 5'h14;
            tcnt_q <= 32'h00000000;
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          EE_CS_O <= 1'b1;
          if (tick) begin
            sk_phase_q <= !sk_phase_q;
            EE_SK_O <= sk_phase_q;
            if (!sk_phase_q) begin
              // Data-in moves while the serial clock is low, half a bit ahead of its rising edge.
              // The frame ends on a falling edge, so the clock rests low with no short pulse.
              if (bits_q == 5'h00) begin
                state_q <= (cmd_q == `ECBC_CMD_WRITE && !loading_q) ? ST_WAIT : ST_DONE;
              end else begin
                EE_DI_O <= shreg_q[19];
              end
            end else begin
              shreg_q <= {shreg_q[18:0], do_sync};
              bits_q <= bits_q - 5'h01;
            end
          end
        end
        ST_WAIT: begin
          // The EEPROM pulls data-out high when its internal write ends; absent, it never does.
          EE_SK_O <= 1'b0;
          tcnt_q <= tcnt_q + 32'h00000001;
          if (do_sync) begin
            state_q <= ST_DONE;
          end else if (tcnt_q >= TOUT_CYCLES - 1) begin
            tout_q <= 1'b1; // [RULE5]
            ev_tout <= 1'b1;
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          EE_CS_O <= 1'b0;
          EE_SK_O <= 1'b0;
          EE_DI_O <= 1'b0;
          sk_phase_q <= 1'b0;
          if (loading_q) begin
            MAC_ADDR_O <= {shreg_q[7:0], MAC_ADDR_O[47:8]};
            if (load_idx_q == `ECBC_MAC_BYTES - 1) begin
              loading_q <= 1'b0;
              loaded_q <= 1'b1;
              busy_q <= 1'b0; // [RULE7]
              ev_load <= 1'b1;
              state_q <= ST_IDLE;
            end else begin
              load_idx_q <= load_idx_q + 3'h1;
              state_q <= ST_GAP;
            end
          end else begin
            if (cmd_q == `ECBC_CMD_READ) begin
              data_q <= shreg_q[7:0]; // [RULE3]
            end
            busy_q <= 1'b0; // [RULE2]
            ev_done <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_GAP: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Sticky status: a set in the same cycle as a clear wins.
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      stat_q <= 3'h0;
      en_q <= 3'h0;
      IRQ_O <= 1'b0;
    end else begin
      if (wr_en) begin
        en_q <= WDATA_I[2:0];
      end
      stat_q <= (wr_clr ? (stat_q & ~WDATA_I[2:0]) : stat_q) |
        {ev_load, ev_tout, ev_done};
      IRQ_O <= |(stat_q & en_q);
    end
  end

  always @* begin
    case (ADDR_I)
      `ECBC_CMD_OFF: rd_mux = {busy_q, cmd_q, 18'h0, tout_q, loaded_q, addr_q};
      `ECBC_DATA_OFF: rd_mux = {24'h000000, data_q};
      `ECBC_IRQ_STAT_OFF: rd_mux = {29'h0, stat_q};
      `ECBC_IRQ_EN_OFF: rd_mux = {29'h0, en_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RDATA_O <= 32'h00000000;
    end else begin
      RDATA_O <= RD_I ? rd_mux : 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// ### design/ecbc_map.vh
// Register offsets, field positions, command codes and timing counts of the EEPROM command block.
// Assumes a 32-bit register port with word-aligned byte addresses.
`ifndef ECBC_MAP_VH
`define ECBC_MAP_VH
`define ECBC_CMD_OFF 8'hB0
`define ECBC_DATA_OFF 8'hB4
`define ECBC_IRQ_STAT_OFF 8'hB8
`define ECBC_IRQ_CLR_OFF 8'hBC
`define ECBC_IRQ_EN_OFF 8'hC0
`define ECBC_BUSY_BIT 31
`define ECBC_TOUT_BIT 9
`define ECBC_LOADED_BIT 8
`define ECBC_CMD_MSB 30
`define ECBC_CMD_LSB 28
`define ECBC_ADDR_MSB 7
`define ECBC_ADDR_LSB 0
`define ECBC_CMD_READ 3'h0
`define ECBC_CMD_WRITE 3'h3
`define ECBC_EV_DONE 0
`define ECBC_EV_TOUT 1
`define ECBC_EV_LOAD 2
`define ECBC_MAC_BYTES 6
`define ECBC_BIT_PERIOD_NS 1000
`define ECBC_CLK_PERIOD_NS 4
`define ECBC_TOUT_US 30000
`endif

// ### design/ecbc_divider.v
// Bit-rate enable generator for the serial EEPROM link.
// Assumes one system clock; emits a one-cycle enable pulse every DIV cycles while run_i is high, none while it is low.
`timescale 1ns/100ps
`default_nettype none
module ecbc_divider #(
  parameter integer DIV = 250
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire run_i,
  output reg tick_o
);
  reg [15:0] cnt_q;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 16'h0000;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt_q <= 16'h0000;
      tick_o <= 1'b0;
    end else if (cnt_q == DIV[15:0] - 16'h0001) begin
      cnt_q <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### design/ecbc_sync.v
// Three-stage input synchroniser for the EEPROM data-out pin.
// A change is taken once the second and third stages agree.
`timescale 1ns/100ps
`default_nettype none
module ecbc_sync (
  input wire clk_i,
  input wire rst_n_i,
  input wire pin_i,
  output reg level_o
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_o <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

// ### test/ecbc_top_sva.sv
// Port-level checker for the EEPROM command block.
// Assumes it is bound to ecbc_top and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module ecbc_top_sva (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic IRQ_O,
  input wire logic EE_CS_O,
  input wire logic EE_SK_O
);
  logic [2:0] en_q;
  logic [10:0] cnt_q;
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      en_q <= 3'h0;
      cnt_q <= 11'h000;
    end else begin
      if (WR_I && ADDR_I == 8'hC0) begin
        en_q <= WDATA_I[2:0];
      end
      if (cnt_q != 11'h7FF) begin
        cnt_q <= cnt_q + 11'h001;
      end
    end
  end
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  rd_idle_zero_a: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
    else $error("read data not zero outside its slot");
  reset_quiet_a: assert property (disable iff (1'b0) !RST_N_I |-> !EE_CS_O && !IRQ_O && RDATA_O == 32'h0)
    else $error("outputs active during reset");
  load_start_a: assert property ($rose(RST_N_I) |-> ##[0:8] EE_CS_O)
    else $error("address load did not start after reset");
  sk_slow_a: assert property ($changed(EE_SK_O) |=> $stable(EE_SK_O)[*8])
    else $error("serial clock toggles too fast");
  cs_hold_a: assert property ($rose(EE_CS_O) |-> EE_CS_O[*8])
    else $error("select dropped early");
  irq_masked_a: assert property (en_q == 3'h0 && $past(en_q) == 3'h0 |-> !IRQ_O)
    else $error("interrupt high while all sources masked");
  early_busy_a: assert property (cnt_q < 11'h3E8 && RD_I && ADDR_I == 8'hB0 |=> RDATA_O[31])
    else $error("busy not seen soon after reset");
  data_width_a: assert property (RD_I && ADDR_I == 8'hB4 |=> RDATA_O[31:8] == 24'h0)
    else $error("data register upper bits not zero");
endmodule
`default_nettype wire

// ### test/ecbc_eeprom_model.sv
// Serial EEPROM stand-in holding erased contents, so every bit read is one; it records the last frame sent.
// Assumes a pull-down on the data-out line, which reads low when no part is fitted or not selected.
`timescale 1ns/100ps
`default_nettype none
module ecbc_eeprom_model (
  input wire logic present_i,
  input wire logic cs_i,
  input wire logic sk_i,
  input wire logic di_i,
  output logic do_o,
  output logic [19:0] frame_o
);
  // Erased cells and the ready level after a write both read high while selected.
  assign do_o = present_i && cs_i;
  initial frame_o = 20'h00000;
  always @(posedge sk_i) begin
    if (cs_i) begin
      frame_o <= {frame_o[18:0], di_i};
    end
  end
endmodule
`default_nettype wire

// ### test/ecbc_top_tb.sv
// Self-checking bench for the EEPROM command block with a model EEPROM.
// Assumes the register map and bit layout of the block's header file.
`timescale 1ns/100ps
`default_nettype none
`include "ecbc_map.vh"
module ecbc_top_tb;
  logic clk, rst_n, wr, rd, present, ee_do, irq, cs, sk, di;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [47:0] mac;
  logic [19:0] frame;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  ecbc_top #(.TOUT_CYCLES(200)) i_ecbc_top (.REF_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq), .EE_CS_O(cs), .EE_SK_O(sk), .EE_DI_O(di),
    .EE_DO_I(ee_do), .MAC_ADDR_O(mac));
  ecbc_eeprom_model i_ecbc_eeprom_model (.present_i(present), .cs_i(cs), .sk_i(sk), .di_i(di), .do_o(ee_do),
    .frame_o(frame));
  task automatic complete_run;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s exp %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= v; end
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk) begin rd <= 1'b1; addr <= a; end
    @(posedge clk) rd <= 1'b0;
    @(posedge clk) v = rdata;
  endtask
  task automatic wait_idle;
    d = 32'h8000_0000;
    while (d[31] !== 1'b0) begin
      repeat (40) @(posedge clk);
      rd_reg(8'hB0, d);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 99000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    rst_n = 1'b1; wr = 1'b0; rd = 1'b0; present = 1'b1; addr = 8'h00; wdata = 32'h0;
    #1 rst_n = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(8'hB0, d);
    chk("busy after reset", d[31], 1'b1);
    wait_idle();
    chk("station address", mac, 48'hFFFF_FFFF_FFFF);
    chk("load frame", frame, {1'b1, `ECBC_CMD_READ, 8'h05, 8'h00});
    rd_reg(8'hB8, d);
    chk("load event", d[2:0], 3'h4);
    wr_reg(8'hC0, 32'h4);
    repeat (3) @(posedge clk);
    chk("irq raised", irq, 1'b1);
    wr_reg(8'hBC, 32'h4);
    repeat (3) @(posedge clk);
    chk("irq cleared", irq, 1'b0);
    rd_reg(8'h10, d);
    chk("unmapped read", d, 32'h0);
    wr_reg(8'hB0, 32'h8000_005A);
    rd_reg(8'hB0, d);
    chk("busy during read", d[31], 1'b1);
    wr_reg(8'hB0, 32'h0000_0011);
    rd_reg(8'hB0, d);
    chk("zero write ignored", {d[31], d[7:0]}, 9'h15A);
    wait_idle();
    rd_reg(8'hB4, d);
    chk("read data", d, 32'hFF);
    chk("read frame", frame, {1'b1, `ECBC_CMD_READ, 8'h5A, 8'h00});
    rd_reg(8'hB8, d);
    chk("done event", d[0], 1'b1);
    present <= 1'b0;
    wr_reg(8'hB4, 32'h3C);
    wr_reg(8'hB0, 32'hB000_0021);
    wait_idle();
    chk("timeout flag", d[9], 1'b1);
    chk("write frame", frame, {1'b1, `ECBC_CMD_WRITE, 8'h21, 8'h3C});
    rd_reg(8'hB8, d);
    chk("timeout event", d[1], 1'b1);
    complete_run();
  end
endmodule
bind ecbc_top ecbc_top_sva i_ecbc_top_sva (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .IRQ_O(IRQ_O), .EE_CS_O(EE_CS_O),
  .EE_SK_O(EE_SK_O));
`default_nettype wire
